/* File: hdl/icache_ctrl.sv */
/*
 * Four-way instruction cache shared by the instruction and data code
 * buses, with line fill, least-recently-used replacement, a locked
 * segment in way 0 and a bypass mode.
 * Assumes one clock, synchronous requests, and a backing memory that
 * answers a line request with four 64-bit beats in address order.
 */
`timescale 1ns/1ns
module icache_ctrl #(
    parameter logic [31:0] DDR_BASE = icache_pkg::DDR_BASE_DEF
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic ce, // clock enable, freezes all state
    input wire logic cache_en, // 0: bypass every fetch
    input wire logic lock_en, // keep locked segment
    input wire logic lock_start, // pulse: load segment
    input wire logic [icache_pkg::ADDR_W-1:0] lock_base, // segment start, 2 KB aligned
    input wire logic ic_req, // instruction bus request
    input wire logic [icache_pkg::ADDR_W-1:0] ic_addr, // instruction bus address
    output logic ic_ready, // request accepted when high
    output logic ic_rvalid, // one-cycle data strobe
    output logic [icache_pkg::WORD_W-1:0] ic_rdata, // instruction word
    input wire logic dc_req, // data code bus request
    input wire logic [icache_pkg::ADDR_W-1:0] dc_addr, // data code bus address
    output logic dc_ready, // request accepted when high
    output logic dc_rvalid, // one-cycle data strobe
    output logic [icache_pkg::WORD_W-1:0] dc_rdata, // data code word
    output logic mem_req, // one-cycle memory request
    output logic [icache_pkg::ADDR_W-1:0] mem_addr, // line or beat address
    output logic mem_line, // 1: four beats, 0: one
    output logic mem_ddr, // target is off-chip region
    input wire logic mem_rvalid, // beat valid
    input wire logic [icache_pkg::MEM_W-1:0] mem_rdata, // 64-bit beat
    output logic lock_busy, // segment load running
    output logic lock_done // segment held
);
    import icache_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [MEM_W-1:0] data_a [SETS*WAYS*BEATS];
    logic [TAG_W-1:0] tag_a [SETS][WAYS];
    logic val_a [SETS][WAYS];
    logic [WAY_W-1:0] age_a [SETS][WAYS];
    ctl_t s_r, s_nxt;

    // lookup of one address in its set
    function automatic logic [WAY_W:0] look(input logic [ADDR_W-1:0] a);
        logic [WAY_W:0] r;
        r = '0;
        for (int w = 0; w < WAYS; w++) begin
            if (val_a[a[OFF_W+IDX_W-1:OFF_W]][w] && tag_a[a[OFF_W+IDX_W-1:OFF_W]][w] ==
                a[ADDR_W-1:OFF_W+IDX_W]) begin
                r = {1'b1, WAY_W'(w)};
            end
        end
        return r;
    endfunction

    // word of a hit line
    function automatic logic [WORD_W-1:0] word(input logic [ADDR_W-1:0] a,
        input logic [WAY_W-1:0] w);
        logic [MEM_W-1:0] d;
        d = data_a[{a[OFF_W+IDX_W-1:OFF_W], w, a[OFF_W-1:BEAT_LSB]}];
        return a[HALF_BIT] ? d[MEM_W-1:WORD_W] : d[WORD_W-1:0];
    endfunction

    // victim: first invalid way, else the oldest; way 0 skipped when locked
    function automatic logic [WAY_W-1:0] victim(input logic [IDX_W-1:0] set,
        input logic lk);
        logic [WAY_W-1:0] v;
        logic found;
        v = lk ? 2'h1 : 2'h0;
        found = 1'b0;
        for (int w = 0; w < WAYS; w++) begin
            if (!(lk && w == 0) && !found) begin
                if (!val_a[set][w]) begin
                    v = WAY_W'(w);
                    found = 1'b1;
                end else if (age_a[set][w] > age_a[set][v]) begin
                    v = WAY_W'(w);
                end
            end
        end
        return v;
    endfunction

    logic [WAY_W:0] ic_lk, dc_lk, pa_lk;
    logic dwe, twe, t0, t1;
    logic [IDX_W-1:0] wset, t0s, t1s;
    logic [WAY_W-1:0] wway, t0w, t1w;
    logic [TAG_W-1:0] wtag;
    logic [ADDR_W-1:0] la;

    assign ic_lk = look(ic_addr);
    assign dc_lk = look(dc_addr);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.ic_v = 1'b0;
        s_nxt.dc_v = 1'b0;
        s_nxt.mreq = 1'b0;
        dwe = 1'b0;
        twe = 1'b0;
        t0 = 1'b0;
        t1 = 1'b0;
        t0s = ic_addr[OFF_W+IDX_W-1:OFF_W];
        t1s = dc_addr[OFF_W+IDX_W-1:OFF_W];
        t0w = ic_lk[WAY_W-1:0];
        t1w = dc_lk[WAY_W-1:0];
        wset = s_r.maddr[OFF_W+IDX_W-1:OFF_W];
        wway = s_r.vic;
        wtag = s_r.maddr[ADDR_W-1:OFF_W+IDX_W];
        la = '0;
        pa_lk = '0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (s_r.rdy && lock_start) begin
                    s_nxt.st = ST_LOCK;
                    s_nxt.lset = '0;
                    s_nxt.beat = '0;
                    s_nxt.locked = 1'b0;
                    s_nxt.mreq = 1'b1;
                    s_nxt.mline = 1'b1;
                    s_nxt.maddr = {lock_base[ADDR_W-1:OFF_W+IDX_W], {(OFF_W+IDX_W){1'b0}}};
                    s_nxt.mddr = lock_base >= DDR_BASE;
                end else if (s_r.rdy) begin
                    if (ic_req && cache_en && ic_lk[WAY_W]) begin
                        s_nxt.ic_v = 1'b1;
                        s_nxt.ic_d = word(ic_addr, ic_lk[WAY_W-1:0]);
                        t0 = 1'b1;
                    end else if (ic_req) begin
                        s_nxt.pend[0] = 1'b1;
                        s_nxt.pa0 = ic_addr;
                    end
                    if (dc_req && cache_en && dc_lk[WAY_W]) begin
                        s_nxt.dc_v = 1'b1;
                        s_nxt.dc_d = word(dc_addr, dc_lk[WAY_W-1:0]);
                        t1 = !(t0 && t0s == t1s);
                    end else if (dc_req) begin
                        s_nxt.pend[1] = 1'b1;
                        s_nxt.pa1 = dc_addr;
                    end
                end
            end
            ST_FILL: begin
                if (mem_rvalid) begin
                    la = s_r.cur ? s_r.pa1 : s_r.pa0;
                    if (s_r.mline) begin
                        dwe = 1'b1;
                        s_nxt.beat = s_r.beat + 2'h1;
                    end
                    if (!s_r.mline || s_r.beat == LAST_BEAT) begin
                        twe = s_r.mline;
                        t0 = s_r.mline;
                        t0s = wset;
                        t0w = s_r.vic;
                        s_nxt.ic_v = !s_r.cur;
                        s_nxt.dc_v = s_r.cur;
                        // earlier beats already sit in the array, the last is still on the bus
                        if (s_r.mline && la[OFF_W-1:BEAT_LSB] != LAST_BEAT) begin
                            s_nxt.ic_d = word(la, s_r.vic);
                        end else begin
                            s_nxt.ic_d = la[HALF_BIT] ? mem_rdata[MEM_W-1:WORD_W] :
                                mem_rdata[WORD_W-1:0];
                        end
                        s_nxt.dc_d = s_nxt.ic_d;
                        s_nxt.pend[s_r.cur] = 1'b0;
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_LOCK: begin
                wset = s_r.lset;
                wway = LOCK_WAY;
                wtag = s_r.maddr[ADDR_W-1:OFF_W+IDX_W];
                if (mem_rvalid) begin
                    dwe = 1'b1;
                    s_nxt.beat = s_r.beat + 2'h1;
                    if (s_r.beat == LAST_BEAT) begin
                        twe = 1'b1;
                        s_nxt.lset = s_r.lset + 6'h1;
                        s_nxt.maddr = s_r.maddr + ADDR_W'(LINE_BYTES);
                        if (s_r.lset == LAST_SET) begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.locked = 1'b1;
                        end else begin
                            s_nxt.mreq = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        if (!lock_en) begin
            s_nxt.locked = 1'b0;
        end
        s_nxt.ldone = s_nxt.locked;
        // launch the next pending miss, rechecking arrays that do not yet hold the line the other bus just filled
        s_nxt.rdy = 1'b0;
        if (s_nxt.st == ST_IDLE && !s_nxt.mreq && s_r.st != ST_IDLE && s_nxt.pend == 2'h0) begin
            s_nxt.rdy = 1'b1;
        end else if (s_r.st == ST_IDLE && s_nxt.st == ST_IDLE && s_nxt.pend == 2'h0) begin
            s_nxt.rdy = 1'b1;
        end else if (s_r.st != ST_LOCK && s_nxt.st == ST_IDLE && s_nxt.pend != 2'h0) begin
            s_nxt.cur = !s_nxt.pend[0];
            la = s_nxt.cur ? s_nxt.pa1 : s_nxt.pa0;
            pa_lk = look(la);
            if (cache_en && pa_lk[WAY_W] && s_r.st == ST_FILL) begin
                s_nxt.ic_v = !s_nxt.cur;
                s_nxt.dc_v = s_nxt.cur;
                s_nxt.ic_d = word(la, pa_lk[WAY_W-1:0]);
                s_nxt.dc_d = s_nxt.ic_d;
                s_nxt.pend[s_nxt.cur] = 1'b0;
                s_nxt.rdy = s_nxt.pend == 2'h0;
            end else begin
                s_nxt.st = ST_FILL;
                s_nxt.mreq = 1'b1;
                s_nxt.mline = cache_en;
                s_nxt.beat = '0;
                s_nxt.maddr = cache_en ? {la[ADDR_W-1:OFF_W], {OFF_W{1'b0}}} :
                    {la[ADDR_W-1:BEAT_LSB], {BEAT_LSB{1'b0}}};
                s_nxt.mddr = la >= DDR_BASE;
                s_nxt.vic = victim(la[OFF_W+IDX_W-1:OFF_W], s_nxt.locked);
            end
        end
    end

    // ------------------------------------------------------------
    // registers and arrays
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.rdy <= 1'b1;
            for (int i = 0; i < SETS; i++) begin
                for (int w = 0; w < WAYS; w++) begin
                    val_a[i][w] <= 1'b0;
                    age_a[i][w] <= WAY_W'(w);
                end
            end
        end else if (ce) begin
            s_r <= s_nxt;
            if (dwe) begin
                data_a[{wset, wway, s_r.beat}] <= mem_rdata;
                val_a[wset][wway] <= twe;
            end
            if (twe) begin
                tag_a[wset][wway] <= wtag;
            end
            // most recent way to age 0, younger ways age by one
            for (int w = 0; w < WAYS; w++) begin
                if (t0 && age_a[t0s][w] < age_a[t0s][t0w]) begin
                    age_a[t0s][w] <= age_a[t0s][w] + 2'h1;
                end
                if (t1 && age_a[t1s][w] < age_a[t1s][t1w]) begin
                    age_a[t1s][w] <= age_a[t1s][w] + 2'h1;
                end
            end
            if (t0) age_a[t0s][t0w] <= '0;
            if (t1) age_a[t1s][t1w] <= '0;
        end
    end

    // outputs straight from the state register
    assign ic_ready = s_r.rdy;
    assign dc_ready = s_r.rdy;
    assign ic_rvalid = s_r.ic_v;
    assign ic_rdata = s_r.ic_d;
    assign dc_rvalid = s_r.dc_v;
    assign dc_rdata = s_r.dc_d;
    assign mem_req = s_r.mreq;
    assign mem_addr = s_r.maddr;
    assign mem_line = s_r.mline;
    assign mem_ddr = s_r.mddr;
    assign lock_busy = s_r.st == ST_LOCK;
    assign lock_done = s_r.ldone;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_GEOMETRY: assert property (@(posedge ref_clk) SETS * WAYS * LINE_BYTES == 8192)
        else $error("cache geometry is not 8 Kbyte");
    AST_HIT_ZERO_WAIT: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        ic_ready && ic_req && cache_en && ic_lk[WAY_W] |=> ic_rvalid)
        else $error("instruction hit not answered next cycle");
    AST_SHARED: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        dc_ready && dc_req && cache_en && dc_lk[WAY_W] && ic_req && ic_lk[WAY_W]
        |=> dc_rvalid && ic_rvalid)
        else $error("shared hits not both answered");
    AST_LINE_FILL: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        mem_req && mem_line && !lock_busy |-> mem_addr[OFF_W-1:0] == 5'h00)
        else $error("line fill not line aligned");
    AST_LOCK_LOAD: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        lock_busy && mem_rvalid && s_r.beat == LAST_BEAT && s_r.lset == LAST_SET && lock_en
        |=> lock_done && !lock_busy)
        else $error("lock load did not finish");
    AST_LOCK_KEEP: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        s_r.locked && s_r.st == ST_FILL |-> s_r.vic != LOCK_WAY)
        else $error("locked way chosen as victim");
    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        !cache_en && ic_req && ic_ready |=> !ic_rvalid ##0 mem_req && !mem_line)
        else $error("bypass fetch not sent to memory");
    AST_REGION: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        mem_req && !lock_busy |-> mem_ddr == (mem_addr >= DDR_BASE))
        else $error("region select wrong");
    AST_NO_ALLOC: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        s_r.st == ST_FILL && !s_r.mline |-> !dwe && !twe && !t0 && !t1)
        else $error("bypass touched cache state");
    COV_HIT: cover property (@(posedge ref_clk) ic_rvalid && s_r.st == ST_IDLE && !mem_req);
    COV_FILL: cover property (@(posedge ref_clk) s_r.st == ST_FILL ##1 ic_rvalid);
    COV_LOCK: cover property (@(posedge ref_clk) $rose(lock_done));
    COV_BOTH: cover property (@(posedge ref_clk) ic_rvalid && dc_rvalid);
endmodule

/* File: hdl/icache_pkg.sv */
/*
 * Constants and state types for the shared instruction cache controller.
 * Assumes 32-bit byte addresses and a 64-bit backing memory read path.
 */
package icache_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int WORD_W = 32;
    localparam int MEM_W = 64;
    localparam int CACHE_BYTES = 8192;
    localparam int WAYS = 4;
    localparam int LINE_BYTES = 32;
    localparam int BEATS = 4;
    localparam int SETS = CACHE_BYTES / (WAYS * LINE_BYTES);
    localparam int OFF_W = 5;
    localparam int IDX_W = 6;
    localparam int TAG_W = ADDR_W - OFF_W - IDX_W;
    localparam int WAY_W = 2;
    localparam int BEAT_W = 2;
    localparam int HALF_BIT = 2;
    localparam int BEAT_LSB = 3;
    localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
    localparam logic [IDX_W-1:0] LAST_SET = 6'h3f;
    localparam logic [WAY_W-1:0] LOCK_WAY = 2'h0;
    // default start of the off-chip memory region
    localparam logic [ADDR_W-1:0] DDR_BASE_DEF = 32'h8000_0000;

    // ------------------------------------------------------------
    // controller state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_LOCK} st_t;

    typedef struct packed {
        st_t st;
        logic rdy;
        logic [1:0] pend;
        logic [ADDR_W-1:0] pa0;
        logic [ADDR_W-1:0] pa1;
        logic cur;
        logic [BEAT_W-1:0] beat;
        logic [WAY_W-1:0] vic;
        logic [IDX_W-1:0] lset;
        logic locked;
        logic ldone;
        logic mreq;
        logic mline;
        logic mddr;
        logic [ADDR_W-1:0] maddr;
        logic ic_v;
        logic [WORD_W-1:0] ic_d;
        logic dc_v;
        logic [WORD_W-1:0] dc_d;
    } ctl_t;
endpackage

/* File: dv/backing_mem_model.sv */
/*
 * Behavioural backing memory behind the cache: answers each request
 * with four or one 64-bit beats, promptly or slowly.
 * Assumes one-cycle request pulses that never overlap a reply.
 */
`timescale 1ns/1ns
module backing_mem_model (
    input wire logic ref_clk, // system clock
    input wire logic mem_req, // request pulse
    input wire logic [31:0] mem_addr, // first beat address
    input wire logic mem_line, // four beats when high
    input wire logic slow, // three cycles per beat
    output logic mem_rvalid, // beat strobe
    output logic [63:0] mem_rdata // beat data
);
    logic [31:0] a;
    int i;

    // word held at a byte address
    function automatic logic [31:0] word(input logic [31:0] x);
        return {x[15:0], x[31:16]} ^ 32'h5a3c_0000;
    endfunction

    // ------------------------------------------------------------
    // reply engine
    // ------------------------------------------------------------
    // idle data flips every cycle so a stale beat never passes
    initial begin
        mem_rvalid = 1'b0;
        mem_rdata = 64'h0;
        forever begin
            @(posedge ref_clk);
            #1;
            mem_rvalid = 1'b0;
            mem_rdata = ~mem_rdata;
            if (mem_req === 1'b1) begin
                a = {mem_addr[31:3], 3'h0};
                for (i = 0; i < (mem_line ? 4 : 1); i++) begin
                    repeat (slow ? 2 : 0) begin
                        @(posedge ref_clk);
                        #1;
                        mem_rvalid = 1'b0;
                        mem_rdata = ~mem_rdata;
                    end
                    @(posedge ref_clk);
                    #1;
                    mem_rvalid = 1'b1;
                    mem_rdata = {word(a + 32'h4), word(a)};
                    a = a + 32'h8;
                end
            end
        end
    end
endmodule

/* File: dv/instruction_cache_controller_tb.sv */
/*
 * Self-checking bench for the shared instruction cache controller.
 * Assumes the backing memory model beside it and the package geometry.
 */
`timescale 1ns/1ns
module instruction_cache_controller_tb;
    import icache_pkg::*;
    logic ref_clk, reset, ce, cache_en, lock_en, lock_start, slow;
    logic [ADDR_W-1:0] lock_base, ic_addr, dc_addr, mem_addr;
    logic ic_req, ic_ready, ic_rvalid, dc_req, dc_ready, dc_rvalid;
    logic [WORD_W-1:0] ic_rdata, dc_rdata;
    logic mem_req, mem_line, mem_ddr, mem_rvalid, lock_busy, lock_done;
    logic [MEM_W-1:0] mem_rdata;
    logic [31:0] ic_q[$];
    logic [31:0] dc_q[$];
    logic [15:0] r;
    int lru_k[10] = '{0, 1, 2, 3, 0, 4, 0, 2, 3, 1};
    logic [9:0] lru_h = 10'b0111010000;
    int bad_count = 0;
    int compares = 0;
    int k, w;

    icache_ctrl uut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .cache_en(cache_en),
        .lock_en(lock_en), .lock_start(lock_start), .lock_base(lock_base),
        .ic_req(ic_req), .ic_addr(ic_addr), .ic_ready(ic_ready), .ic_rvalid(ic_rvalid),
        .ic_rdata(ic_rdata), .dc_req(dc_req), .dc_addr(dc_addr), .dc_ready(dc_ready),
        .dc_rvalid(dc_rvalid), .dc_rdata(dc_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_line(mem_line), .mem_ddr(mem_ddr), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .lock_busy(lock_busy), .lock_done(lock_done));

    backing_mem_model mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_line(mem_line), .slow(slow), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] word(input logic [31:0] x);
        return {x[15:0], x[31:16]} ^ 32'h5a3c_0000;
    endfunction

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one access; hit 1 checks a hit, 0 a miss, x leaves it open
    task automatic xfer(input logic ion, input logic don, input logic [31:0] ia,
        input logic [31:0] da, input logic hit);
        logic [31:0] ma;
        int n;
        ma = ion ? ia : da;
        ic_req = ion;
        ic_addr = ia;
        dc_req = don;
        dc_addr = da;
        n = 0;
        while (ic_ready !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        if (ion) ic_q.push_back(word(ia));
        if (don) dc_q.push_back(word(da));
        #1;
        if (hit === 1'b1) begin
            chk("mem_req on hit", 32'h0, mem_req);
            if (ion) chk("ic_rvalid", 32'h1, ic_rvalid);
            if (don) chk("dc_rvalid", 32'h1, dc_rvalid);
        end else begin
            ic_req = 1'b0;
            dc_req = 1'b0;
            if (hit === 1'b0) begin
                chk("mem_req on miss", 32'h1, mem_req);
                chk("mem_line", cache_en, mem_line);
                chk("mem_addr", cache_en ? {ma[31:5], 5'h0} : {ma[31:3], 3'h0}, mem_addr);
                chk("mem_ddr", ma >= DDR_BASE_DEF, mem_ddr);
            end
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (ic_ready !== 1'b1 && n < 8000);
            if (ic_ready !== 1'b1) chk("ic_ready after miss", 32'h1, ic_ready);
        end
    endtask

    task automatic idle;
        ic_req = 1'b0;
        dc_req = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // returned words against the oldest note of their bus
    always @(posedge ref_clk) begin
        #2;
        if (ic_rvalid === 1'b1) chk("ic_rdata", ic_q.size() ? ic_q.pop_front() : 'x, ic_rdata);
        if (dc_rvalid === 1'b1) chk("dc_rdata", dc_q.size() ? dc_q.pop_front() : 'x, dc_rdata);
    end

    initial begin
        #300000;
        bad_count++;
        conclude;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        cache_en = 1'b1;
        lock_en = 1'b0;
        lock_start = 1'b0;
        lock_base = 32'h0;
        slow = 1'b0;
        ic_req = 1'b0;
        dc_req = 1'b0;
        ic_addr = 32'h0;
        dc_addr = 32'h0;
        r = 16'h0028;
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        xfer(1'b1, 1'b0, 32'h0000_1004, 32'h0, 1'b0);
        xfer(1'b1, 1'b0, 32'h0000_101c, 32'h0, 1'b1);
        xfer(1'b1, 1'b0, 32'h8000_2010, 32'h0, 1'b0);
        xfer(1'b0, 1'b1, 32'h0, 32'h8000_2008, 1'b1);
        xfer(1'b1, 1'b1, 32'h0000_1000, 32'h8000_201c, 1'b1);
        xfer(1'b1, 1'b1, 32'h0000_5000, 32'h0000_5820, 1'b0);
        $display("test regions done");
        slow = 1'b1;
        for (k = 0; k < 10; k++)
            xfer(~k[0], k[0], 32'h64 + 32'(lru_k[k] * 2048), 32'h64 + 32'(lru_k[k] * 2048),
                lru_h[k]);
        idle;
        $display("test replacement done");
        cache_en = 1'b0;
        xfer(1'b1, 1'b0, 32'h0000_4008, 32'h0, 1'b0);
        xfer(1'b0, 1'b1, 32'h0, 32'h0000_4008, 1'b0);
        xfer(1'b1, 1'b0, 32'h0000_1004, 32'h0, 1'b0);
        cache_en = 1'b1;
        xfer(1'b1, 1'b0, 32'h0000_4008, 32'h0, 1'b0);
        xfer(1'b1, 1'b0, 32'h0000_1004, 32'h0, 1'b1);
        idle;
        $display("test bypass done");
        lock_en = 1'b1;
        for (k = 0; k < 2; k++) begin
            lock_base = k ? 32'h8001_0000 : 32'h0001_0000;
            lock_start = 1'b1;
            @(posedge ref_clk);
            #1;
            lock_start = 1'b0;
            chk("lock_busy", 32'h1, lock_busy);
            for (w = 0; w < 6000 && lock_busy === 1'b1; w++) @(posedge ref_clk);
            #1;
            chk("lock_done", 32'h1, lock_done);
            xfer(1'b1, 1'b0, lock_base + 32'h7e4, 32'h0, 1'b1);
            xfer(1'b0, 1'b1, 32'h0, lock_base + 32'h10, 1'b0 + 1'b1);
            for (w = 0; w < 5; w++)
                xfer(1'b1, 1'b0, 32'h0003_0000 + 32'(w * 2048), 32'h0, 1'b0);
            xfer(1'b1, 1'b0, lock_base, 32'h0, 1'b1);
            idle;
        end
        lock_en = 1'b0;
        @(posedge ref_clk);
        #1;
        chk("lock_done released", 32'h0, lock_done);
        $display("test lock done");
        for (k = 0; k < 24; k++) begin
            r = lfsr(r);
            slow = r[0];
            cache_en = r[1] | r[2];
            xfer(r[15], ~r[15], {18'h0, r[13:2], 2'h0}, {18'h0, r[13:2], 2'h0}, 1'bx);
        end
        repeat (2) @(posedge ref_clk);
        #1;
        chk("notes left", 32'h0, 32'(ic_q.size() + dc_q.size()));
        $display("test random done");
        conclude;
    end
endmodule
